// ===== rtl/tcdma_defs.svh
// Purpose: Offsets, field positions and reset values of the DMA control block
// Assumes: Word-aligned AHB-Lite map, index times four gives byte address
// Notes:   Included by the control block design file only; the package does not include it
`ifndef TCDMA_DEFS_SVH
`define TCDMA_DEFS_SVH

// Register indices (byte address is four times the index)
`define TCDMA_IDX_MEM_LO   8'h28
`define TCDMA_IDX_MEM_HI   8'h29
`define TCDMA_IDX_MEM_UP   8'h2A
`define TCDMA_IDX_PORT_LO  8'h2B
`define TCDMA_IDX_PORT_HI  8'h2C
`define TCDMA_IDX_PORT_UP  8'h2D
`define TCDMA_IDX_STATUS   8'h30
`define TCDMA_IDX_MODE     8'h31
`define TCDMA_IDX_WAIT     8'h32
`define TCDMA_IDX_VECTOR   8'h33
`define TCDMA_IDX_CNT0_LO  8'h34
`define TCDMA_IDX_CNT0_HI  8'h35
`define TCDMA_IDX_CNT1_LO  8'h36
`define TCDMA_IDX_CNT1_HI  8'h37

// Status register fields
`define TCDMA_ST_EN1   7
`define TCDMA_ST_EN0   6
`define TCDMA_ST_WG1   5
`define TCDMA_ST_WG0   4
`define TCDMA_ST_IE1   3
`define TCDMA_ST_IE0   2
`define TCDMA_ST_ME    0

// Reset values
`define TCDMA_RST_PORT_UP  8'h00
`define TCDMA_RST_WAIT     8'hF0
`define TCDMA_RST_MODE     8'h00
`define TCDMA_RST_VECTOR   3'h0

// Port pointer upper byte fields
`define TCDMA_PU_TIMER_SEL 3
`define TCDMA_SRC_PIN      2'h0
`define TCDMA_SRC_SER0     2'h1
`define TCDMA_SRC_SER1     2'h2

// Mode encodings
`define TCDMA_AM_INC   2'h0
`define TCDMA_AM_DEC   2'h1
`define TCDMA_AM_FIX   2'h2
`define TCDMA_AM_IO    2'h3

`endif

// ===== rtl/tcdma_pkg.sv
// Purpose: Types shared by the DMA control block
// Assumes: Constants come from tcdma_defs.svh
// Notes:   Nothing is imported; names are written with the package prefix
package tcdma_pkg;

  // Transfer sequencer states, one sequencer shared by both channels
  typedef enum logic [1:0] {
    IDLE,
    READ,
    WRITE,
    GAP
  } tcdma_state_t;

endpackage : tcdma_pkg

// ===== rtl/tcdma_req_sync.sv
// Purpose: Synchronise one request pin and apply level or edge sense
// Assumes: Pin is asynchronous to CLK_I
// Notes:   Edge mode latches a rising edge until the sequencer takes it
`timescale 1ns/1ps
module tcdma_req_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Request pin and control
  input  wire logic req_i,     // Raw request, active high
  input  wire logic edge_i,    // One selects edge sense
  input  wire logic take_i,    // Sequencer consumed a request
  // Result
  output logic      pending_o  // Request seen
);

  // All state in one struct
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic hit;
  } tcdma_sync_t;

  tcdma_sync_t q_r;   // Registered state
  tcdma_sync_t q_nxt; // Next state

  // Next-state logic; only s2 and s3 are compared, never s1
  always_comb
  begin
    q_nxt    = q_r;
    q_nxt.s1 = req_i;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    // Level changes once second and third stages agree
    if (q_r.s2 == q_r.s3)
    begin
      q_nxt.lvl = q_r.s3;
    end
    // Latch a rising edge; set wins over a take
    if (q_r.s2 && q_r.s3 && !q_r.lvl)
    begin
      q_nxt.hit = 1'b1;
    end
    else if (take_i)
    begin
      q_nxt.hit = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  // Level sense follows the filtered pin, edge sense the latch
  assign pending_o = edge_i ? q_r.hit : q_r.lvl;

endmodule : tcdma_req_sync

// ===== rtl/tcdma_ctrl.sv
// Purpose: Two-channel DMA control and register logic with AHB-Lite slave
// Assumes: 20 MHz CLK_I, synchronous active-high SRST_I, word registers
// Notes:   Bus cycles are issued as read/write strobes to a memory/port
//          engine outside; MEM_DONE_I acknowledges each machine cycle
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "tcdma_defs.svh"
module tcdma_ctrl (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SRST_I,
  // AHB-Lite slave
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic [31:0]      HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  // System events
  input  wire logic        NMI_I,       // Non-maskable interrupt pulse
  // Request sources
  input  wire logic        EXT_REQ_I,   // External request pin
  input  wire logic        TMR_REQ_I,   // Shared timer/request pin
  input  wire logic        SER0_REQ_I,  // First serial transmitter ready
  input  wire logic        SER1_REQ_I,  // Second serial transmitter ready
  // Transfer engine handshake
  output logic             RD_STB_O,    // Read cycle request
  output logic             WR_STB_O,    // Write cycle request
  output logic             CYC_IO_O,    // Cycle targets I/O space
  output logic [1:0]       CYC_CH_O,    // One-hot channel of cycle
  input  wire logic        MEM_DONE_I,  // Cycle complete
  output logic             BUS_HOLD_O,  // DMA owns the bus
  // Configuration outputs
  output logic [1:0]       MEM_WAIT_O,
  output logic [1:0]       PORT_WAIT_O,
  output logic [2:0]       VEC_HI_O,
  output logic             TMR_OUT_SEL_O,
  output logic             IRQ_O
);

  // All state of the block
  typedef struct packed {
    logic [19:0]  mptr1;   // Channel 1 memory pointer
    logic [15:0]  pptr1;   // Channel 1 port pointer
    logic [7:0]   pup1;    // Port pointer upper byte
    logic         en1;
    logic         en0;
    logic         ie1;
    logic         ie0;
    logic         me;
    logic [7:0]   mode0;   // Channel 0 mode register
    logic [7:0]   wctl;    // Wait, request sense of both channels and channel 1 control
    logic [2:0]   vec;
    logic [15:0]  cnt0;
    logic [15:0]  cnt1;
    tcdma_pkg::tcdma_state_t st;
    logic         ch;      // Active channel, 1 = channel 1
    logic         dp_act;  // AHB data phase pending
    logic         dp_wr;
    logic [7:0]   dp_idx;
    logic [31:0]  rdata;
  } tcdma_regs_t;

  tcdma_regs_t r_r;   // Registered state
  tcdma_regs_t r_nxt; // Next state
  logic        pend0; // Channel 0 request pending
  logic        pend1; // Channel 1 request pending
  logic        take0; // Channel 0 request consumed
  logic        take1; // Channel 1 request consumed
  logic        raw0;  // Selected request for channel 0
  logic        raw1;  // Selected request for channel 1

  // Decoded mode fields
  logic [1:0] dmode0;
  logic [1:0] smode0;
  logic       io0;
  logic       run0;
  logic       run1;
  logic       rdy0;
  logic       rdy1;
  assign dmode0 = r_r.mode0[5:4];
  assign smode0 = r_r.mode0[3:2];
  assign io0    = (dmode0 == `TCDMA_AM_IO) || (smode0 == `TCDMA_AM_IO);
  assign run1   = r_r.en1 && r_r.me;
  assign run0   = r_r.en0 && r_r.me;
  assign rdy0   = run0 && (io0 ? pend0 : 1'b1);
  assign rdy1   = run1 && pend1;

  // Request source select; channel 1 follows its port pointer upper byte bits
  function automatic logic pick(input logic [1:0] sel, input logic ext);
    case (sel)
      `TCDMA_SRC_PIN:  pick = ext;
      `TCDMA_SRC_SER0: pick = SER0_REQ_I;
      `TCDMA_SRC_SER1: pick = SER1_REQ_I;
      default:         pick = 1'b0;          // Unused code never requests
    endcase
  endfunction : pick

  // Channel 0 address pointers live elsewhere; channel 0 always uses the pin source
  assign raw0 = pick(`TCDMA_SRC_PIN, EXT_REQ_I);
  // Timer pin is no request while it serves as timer output
  assign raw1 = pick(r_r.pup1[1:0],
                     TMR_REQ_I && !r_r.pup1[`TCDMA_PU_TIMER_SEL]);

  // Request sense per channel
  tcdma_req_sync u_sync0 (
    .clk_i     (CLK_I),
    .srst_i    (SRST_I),
    .req_i     (raw0),
    .edge_i    (r_r.wctl[3]),
    .take_i    (take0),
    .pending_o (pend0)
  );
  tcdma_req_sync u_sync1 (
    .clk_i     (CLK_I),
    .srst_i    (SRST_I),
    .req_i     (raw1),
    .edge_i    (r_r.wctl[2]),
    .take_i    (take1),
    .pending_o (pend1)
  );

  assign take0 = (r_r.st == tcdma_pkg::IDLE) && !rdy1 && rdy0;
  assign take1 = (r_r.st == tcdma_pkg::IDLE) && rdy1;

  // Step a memory pointer by its mode
  function automatic logic [19:0] step(input logic [19:0] a,
                                       input logic [1:0]  m);
    case (m)
      `TCDMA_AM_INC: step = a + 20'h00001;
      `TCDMA_AM_DEC: step = a - 20'h00001;
      default:       step = a;
    endcase
  endfunction : step

  // Register read mux
  function automatic logic [7:0] rd_reg(input tcdma_regs_t s,
                                        input logic [7:0]  idx);
    case (idx)
      `TCDMA_IDX_MEM_LO:  rd_reg = s.mptr1[7:0];
      `TCDMA_IDX_MEM_HI:  rd_reg = s.mptr1[15:8];
      `TCDMA_IDX_MEM_UP:  rd_reg = {4'h0, s.mptr1[19:16]};
      `TCDMA_IDX_PORT_LO: rd_reg = s.pptr1[7:0];
      `TCDMA_IDX_PORT_HI: rd_reg = s.pptr1[15:8];
      `TCDMA_IDX_PORT_UP: rd_reg = s.pup1;
      // Gate bits always read as one
      `TCDMA_IDX_STATUS:  rd_reg = {s.en1, s.en0, 2'h3, s.ie1, s.ie0,
                                    1'b0, s.me};
      `TCDMA_IDX_MODE:    rd_reg = {2'h0, s.mode0[5:1], 1'b0};
      `TCDMA_IDX_WAIT:    rd_reg = s.wctl;
      `TCDMA_IDX_VECTOR:  rd_reg = {s.vec, 5'h00};
      `TCDMA_IDX_CNT0_LO: rd_reg = s.cnt0[7:0];
      `TCDMA_IDX_CNT0_HI: rd_reg = s.cnt0[15:8];
      `TCDMA_IDX_CNT1_LO: rd_reg = s.cnt1[7:0];
      `TCDMA_IDX_CNT1_HI: rd_reg = s.cnt1[15:8];
      default:            rd_reg = 8'h00;  // Unmapped reads zero
    endcase
  endfunction : rd_reg

  // Next-state logic: bus slave, status side effects, sequencer
  always_comb
  begin
    logic [7:0] wd;
    logic       done;
    wd    = HWDATA_I[7:0];
    done  = 1'b0;
    r_nxt = r_r;
    r_nxt.rdata = r_r.rdata;
    // Address phase capture
    if (HSEL_I && HREADY_I && HTRANS_I[1])
    begin
      r_nxt.dp_act = 1'b1;
      r_nxt.dp_wr  = HWRITE_I;
      r_nxt.dp_idx = HADDR_I[9:2];
    end
    else if (HREADY_I)
    begin
      r_nxt.dp_act = 1'b0;
    end
    // Read data registered at address phase
    if (HSEL_I && HREADY_I && HTRANS_I[1] && !HWRITE_I)
    begin
      r_nxt.rdata = {24'h000000, rd_reg(r_r, HADDR_I[9:2])};
    end
    // Sequencer; hardware byte-count ends are decided here
    case (r_r.st)
      tcdma_pkg::IDLE:
      begin
        if (rdy1)
        begin
          r_nxt.ch = 1'b1;
          r_nxt.st = tcdma_pkg::READ;
        end
        else if (rdy0)
        begin
          r_nxt.ch = 1'b0;
          r_nxt.st = tcdma_pkg::READ;
        end
      end
      tcdma_pkg::READ:
      begin
        if (MEM_DONE_I)
        begin
          r_nxt.st = tcdma_pkg::WRITE;
        end
      end
      tcdma_pkg::WRITE:
      begin
        if (MEM_DONE_I)
        begin
          done = 1'b1;
          if (r_r.ch)
          begin
            r_nxt.cnt1  = r_r.cnt1 - 16'h0001;
            r_nxt.mptr1 = step(r_r.mptr1, {1'b0, r_r.wctl[0]});
            if (r_r.cnt1 == 16'h0001)
            begin
              r_nxt.en1 = 1'b0;
            end
          end
          else
          begin
            r_nxt.cnt0 = r_r.cnt0 - 16'h0001;
            if (r_r.cnt0 == 16'h0001)
            begin
              r_nxt.en0 = 1'b0;
            end
          end
          // Burst memory transfers go straight on
          if (!r_r.ch && !io0 && r_r.mode0[1] && r_r.cnt0 != 16'h0001)
          begin
            r_nxt.st = tcdma_pkg::READ;
          end
          else
          begin
            r_nxt.st = tcdma_pkg::GAP;
          end
        end
      end
      tcdma_pkg::GAP:
      begin
        r_nxt.st = tcdma_pkg::IDLE;          // CPU gets this cycle
      end
      default:
      begin
        r_nxt.st = tcdma_pkg::IDLE;
      end
    endcase
    // Register writes in data phase
    if (r_r.dp_act && r_r.dp_wr)
    begin
      case (r_r.dp_idx)
        `TCDMA_IDX_MEM_LO:  r_nxt.mptr1[7:0]   = wd;
        `TCDMA_IDX_MEM_HI:  r_nxt.mptr1[15:8]  = wd;
        `TCDMA_IDX_MEM_UP:  r_nxt.mptr1[19:16] = wd[3:0];
        `TCDMA_IDX_PORT_LO: r_nxt.pptr1[7:0]   = wd;
        `TCDMA_IDX_PORT_HI: r_nxt.pptr1[15:8]  = wd;
        `TCDMA_IDX_PORT_UP: r_nxt.pup1         = wd;
        `TCDMA_IDX_STATUS:
        begin
          r_nxt.ie1 = wd[`TCDMA_ST_IE1];
          r_nxt.ie0 = wd[`TCDMA_ST_IE0];
          // Gate low lets the enable through; a one also sets master
          // A gated clear must land even while a byte completes
          if (!wd[`TCDMA_ST_WG1])
          begin
            r_nxt.en1 = wd[`TCDMA_ST_EN1];
          end
          if (!wd[`TCDMA_ST_WG0])
          begin
            r_nxt.en0 = wd[`TCDMA_ST_EN0];
          end
          if ((!wd[`TCDMA_ST_WG1] && wd[`TCDMA_ST_EN1]) ||
              (!wd[`TCDMA_ST_WG0] && wd[`TCDMA_ST_EN0]))
          begin
            r_nxt.me = 1'b1;
          end
        end
        `TCDMA_IDX_MODE:    r_nxt.mode0 = {2'h0, wd[5:1], 1'b0};
        `TCDMA_IDX_WAIT:    r_nxt.wctl  = wd;
        `TCDMA_IDX_VECTOR:  r_nxt.vec   = wd[7:5];
        `TCDMA_IDX_CNT0_LO: r_nxt.cnt0[7:0]  = wd;
        `TCDMA_IDX_CNT0_HI: r_nxt.cnt0[15:8] = wd;
        `TCDMA_IDX_CNT1_LO: r_nxt.cnt1[7:0]  = wd;
        `TCDMA_IDX_CNT1_HI: r_nxt.cnt1[15:8] = wd;
        default:            r_nxt.rdata = r_nxt.rdata; // Ignored
      endcase
    end
    // NMI wins over any master enable set
    if (NMI_I)
    begin
      r_nxt.me = 1'b0;
    end
  end

  // State register
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      r_r       <= '0;
      r_r.pup1  <= `TCDMA_RST_PORT_UP;
      r_r.wctl  <= `TCDMA_RST_WAIT;
      r_r.mode0 <= `TCDMA_RST_MODE;
      r_r.vec   <= `TCDMA_RST_VECTOR;
      r_r.st    <= tcdma_pkg::IDLE;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // Bus answers: zero wait, always OKAY
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = r_r.rdata;

  // Engine handshake; channel 1 direction bit or channel 0 mode fields decide I/O side
  assign RD_STB_O   = (r_r.st == tcdma_pkg::READ);
  assign WR_STB_O   = (r_r.st == tcdma_pkg::WRITE);
  assign CYC_CH_O   = r_r.ch ? 2'h2 : 2'h1;
  assign CYC_IO_O   = r_r.ch ? (RD_STB_O == r_r.wctl[1])
                             : (RD_STB_O ? (smode0 == `TCDMA_AM_IO)
                                         : (dmode0 == `TCDMA_AM_IO));
  assign BUS_HOLD_O = RD_STB_O || WR_STB_O;

  // Configuration outputs
  assign MEM_WAIT_O    = r_r.wctl[7:6];
  assign PORT_WAIT_O   = r_r.wctl[5:4];
  assign VEC_HI_O      = r_r.vec;
  assign TMR_OUT_SEL_O = r_r.pup1[`TCDMA_PU_TIMER_SEL];
  assign IRQ_O = (!r_r.en1 && r_r.ie1) || (!r_r.en0 && r_r.ie0);

  // Interrupt follows disabled channel 1 with its irq enable
  property p_irq;
    @(posedge CLK_I) disable iff (SRST_I)
      (!r_r.en1 && r_r.ie1) |-> IRQ_O;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  // NMI clears master one edge later
  property p_nmi;
    @(posedge CLK_I) disable iff (SRST_I)
      NMI_I |=> !r_r.me;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi kept master");

  // Read is always followed by write
  property p_seq;
    @(posedge CLK_I) disable iff (SRST_I)
      (RD_STB_O && MEM_DONE_I) |=> WR_STB_O;
  endproperty
  a_seq: assert property (p_seq) else $error("no write after read");

  // Master enable never rises without a status write
  property p_me;
    @(posedge CLK_I) disable iff (SRST_I)
      $rose(r_r.me) |-> $past(r_r.dp_act && r_r.dp_wr &&
                              r_r.dp_idx == `TCDMA_IDX_STATUS);
  endproperty
  a_me: assert property (p_me) else $error("master set alone");

  // No cycle starts while master is off
  property p_run;
    @(posedge CLK_I) disable iff (SRST_I)
      (r_r.st == tcdma_pkg::IDLE && !r_r.me) |=> !RD_STB_O;
  endproperty
  a_run: assert property (p_run) else $error("ran while off");

  // Wait fields come out of reset at their maximum, block quiet
  property p_wait;
    @(posedge CLK_I) disable iff (SRST_I)
      $fell(SRST_I) |-> (MEM_WAIT_O == 2'h3) && (PORT_WAIT_O == 2'h3) &&
                        !IRQ_O && !RD_STB_O;
  endproperty
  a_wait: assert property (p_wait) else $error("wait field");

  // Channel 1 count steps by one per byte
  property p_cnt;
    @(posedge CLK_I) disable iff (SRST_I)
      (WR_STB_O && MEM_DONE_I && r_r.ch && !r_r.dp_act)
        |=> r_r.cnt1 == $past(r_r.cnt1) - 16'h0001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count step");

  // Cycle steal leaves a gap before next read
  property p_gap;
    @(posedge CLK_I) disable iff (SRST_I)
      (WR_STB_O && MEM_DONE_I && !r_r.mode0[1]) |=> !RD_STB_O ##1 !RD_STB_O;
  endproperty
  a_gap: assert property (p_gap) else $error("no cpu gap");

endmodule : tcdma_ctrl

// ===== bench/tcdma_engine_model.sv
// Purpose: Memory and port engine that answers the DMA strobes
// Assumes: Strobes hold until done is seen
// Notes:   lat_i stretches each cycle, so answers can be prompt or slow
`timescale 1ns/1ps
module tcdma_engine_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  // Strobes from the controller
  input  wire logic       rd_stb_i,
  input  wire logic       wr_stb_i,
  input  wire logic       io_i,
  input  wire logic [1:0] ch_i,
  input  wire logic [3:0] lat_i,
  // Answer and record
  output logic            done_o,
  output logic [7:0]      rd_n_o,
  output logic [7:0]      wr_n_o,
  output logic            rd_io_o,
  output logic            wr_io_o,
  output logic [1:0]      ch_o,
  output logic            bad_o
);
  logic [3:0] cnt;      // Cycles waited so far
  logic       rd_seen;  // A read is owed its write

  // One done pulse per cycle, after lat_i waits
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      done_o  <= 1'b0;
      cnt     <= 4'h0;
      rd_n_o  <= 8'h00;
      wr_n_o  <= 8'h00;
      rd_io_o <= 1'b0;
      wr_io_o <= 1'b0;
      ch_o    <= 2'h0;
      bad_o   <= 1'b0;
      rd_seen <= 1'b0;
    end
    else if (done_o)
    begin
      done_o <= 1'b0;
      cnt    <= 4'h0;
    end
    else if (rd_stb_i || wr_stb_i)
    begin
      if (cnt == lat_i)
      begin
        done_o <= 1'b1;
        ch_o   <= ch_i;
        // Write without a read first is flagged
        if (rd_stb_i)
        begin
          rd_n_o  <= rd_n_o + 8'h01;
          rd_io_o <= io_i;
          rd_seen <= 1'b1;
        end
        else
        begin
          wr_n_o  <= wr_n_o + 8'h01;
          wr_io_o <= io_i;
          bad_o   <= bad_o | !rd_seen;
          rd_seen <= 1'b0;
        end
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule : tcdma_engine_model

// ===== bench/two_channel_dma_control_bench.sv
// Purpose: Register and transfer tests of the DMA control block
// Assumes: Bus slave answers with zero wait
// Notes:   Engine model answers strobes; bench drives requests
`timescale 1ns/1ps
module two_channel_dma_control_bench;
  logic        clk = 1'b0;      // 50 ns clock
  logic        srst = 1'b1;     // Sync reset
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        nmi = 1'b0;
  logic        ext_req = 1'b0;
  logic        ser0 = 1'b0;
  logic [3:0]  lat = 4'h0;      // Engine delay
  logic [7:0]  r0, w0;          // Counts before a run
  wire  [31:0] hrdata;
  wire         hready, rd_stb, wr_stb, cyc_io, done, tsel, irq;
  wire  [1:0]  cyc_ch, mem_wait, port_wait, ch;
  wire  [2:0]  vec;
  wire  [7:0]  rd_n, wr_n;
  wire         rd_io, wr_io, bad, hresp, bhold;
  int          err_count = 0;
  int          tests_run = 0;
  int          cyc = 0;
  // Memory-only channel 0 modes, never I/O to I/O
  logic [7:0]  modes [4] = '{8'h02, 8'h00, 8'h16, 8'h28};

  always #25 clk = ~clk;

  tcdma_ctrl tcdma_ctrl_inst (
    .CLK_I(clk), .SRST_I(srst), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2),
    .HWDATA_I(hwdata), .HREADY_I(hready), .HRDATA_O(hrdata),
    .HREADYOUT_O(hready), .HRESP_O(hresp), .NMI_I(nmi),
    .EXT_REQ_I(ext_req), .TMR_REQ_I(1'b0), .SER0_REQ_I(ser0),
    .SER1_REQ_I(1'b0), .RD_STB_O(rd_stb), .WR_STB_O(wr_stb),
    .CYC_IO_O(cyc_io), .CYC_CH_O(cyc_ch), .MEM_DONE_I(done),
    .BUS_HOLD_O(bhold), .MEM_WAIT_O(mem_wait), .PORT_WAIT_O(port_wait),
    .VEC_HI_O(vec), .TMR_OUT_SEL_O(tsel), .IRQ_O(irq));

  tcdma_engine_model tcdma_engine_model_inst (
    .clk_i(clk), .srst_i(srst), .rd_stb_i(rd_stb), .wr_stb_i(wr_stb),
    .io_i(cyc_io), .ch_i(cyc_ch), .lat_i(lat), .done_o(done),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .rd_io_o(rd_io), .wr_io_o(wr_io),
    .ch_o(ch), .bad_o(bad));

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One single transfer; settles 1 ns past the data edge
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= {24'h0, d};
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata[7:0];
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, e);
  endtask : rd_chk

  // Arm channel 0 with a mode and a byte count
  task automatic arm0(input logic [7:0] m, input logic [7:0] n);
    wr(8'h31, m);
    wr(8'h34, n);
    wr(8'h35, 8'h00);
    r0 = rd_n;
    w0 = wr_n;
    wr(8'h30, 8'h64);
  endtask : arm0

  // Bounded wait for the end interrupt, then byte counts
  task automatic done_chk(input logic [7:0] n);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    chk({7'h0, irq}, 8'h01);
    chk(rd_n - r0, n);
    chk(wr_n - w0, n);
  endtask : done_chk

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_chk(8'h2D, 8'h00);
    rd_chk(8'h30, 8'h30);
    rd_chk(8'h31, 8'h00);
    rd_chk(8'h32, 8'hF0);
    rd_chk(8'h33, 8'h00);
    chk({4'h0, mem_wait, port_wait}, 8'h0F);
    chk({7'h0, irq}, 8'h00);
    chk({7'h0, hresp}, 8'h00);
    wr(8'h30, 8'hFC);
    rd_chk(8'h30, 8'h3C);
    chk({7'h0, irq}, 8'h01);
    wr(8'h32, 8'h6D);
    rd_chk(8'h32, 8'h6D);
    chk({4'h0, mem_wait, port_wait}, 8'h06);
    wr(8'h32, 8'hF0);
    wr(8'h33, 8'hE0);
    chk({5'h0, vec}, 8'h07);
    wr(8'h2D, 8'h08);
    chk({7'h0, tsel}, 8'h01);
    rd_chk(8'h2D, 8'h08);
    wr(8'h28, 8'hA5);
    rd_chk(8'h28, 8'hA5);
    wr(8'h2A, 8'h0F);
    rd_chk(8'h2A, 8'h0F);
    // Unmapped place: write dropped, reads zero
    wr(8'h3F, 8'h5A);
    rd_chk(8'h3F, 8'h00);
    for (logic [7:0] i = 0; i < 4; i++)
    begin
      lat <= i[3:0];
      arm0(modes[i], i + 8'h01);
      done_chk(i + 8'h01);
    end
    rd_chk(8'h30, 8'h35);
    rd_chk(8'h34, 8'h00);
    // I/O source waits for its request; NMI drops master
    arm0(8'h0C, 8'h01);
    repeat (20) @(posedge clk);
    chk(rd_n - r0, 8'h00);
    chk({7'h0, bhold}, 8'h00);
    @(posedge clk);
    nmi <= 1'b1;
    @(posedge clk);
    nmi <= 1'b0;
    rd_chk(8'h30, 8'h74);
    wr(8'h30, 8'h35);
    rd_chk(8'h30, 8'h74);
    wr(8'h30, 8'h64);
    rd_chk(8'h30, 8'h75);
    @(posedge clk);
    ext_req <= 1'b1;
    done_chk(8'h01);
    chk({7'h0, rd_io}, 8'h01);
    chk({6'h0, ch}, 8'h01);
    // I/O destination, stopped by a gated write, then resumed
    @(posedge clk);
    ext_req <= 1'b0;
    arm0(8'h30, 8'h01);
    wr(8'h30, 8'h24);
    rd_chk(8'h30, 8'h35);
    @(posedge clk);
    ext_req <= 1'b1;
    repeat (20) @(posedge clk);
    chk(rd_n - r0, 8'h00);
    wr(8'h30, 8'h64);
    done_chk(8'h01);
    chk({7'h0, wr_io}, 8'h01);
    @(posedge clk);
    ext_req <= 1'b0;
    // Channel 1: serial source, port to memory
    wr(8'h2D, 8'h01);
    wr(8'h32, 8'hF2);
    wr(8'h36, 8'h01);
    wr(8'h37, 8'h00);
    r0 = rd_n;
    w0 = wr_n;
    lat <= 4'h3;
    wr(8'h30, 8'h98);
    @(posedge clk);
    ser0 <= 1'b1;
    done_chk(8'h01);
    chk({6'h0, ch}, 8'h02);
    chk({6'h0, rd_io, wr_io}, 8'h02);
    rd_chk(8'h30, 8'h39);
    chk({7'h0, bad}, 8'h00);
    // Edge sense on channel 0: a held request moves one byte only
    @(posedge clk);
    ser0 <= 1'b0;
    wr(8'h32, 8'hF8);
    arm0(8'h0C, 8'h02);
    @(posedge clk);
    ext_req <= 1'b1;
    repeat (40) @(posedge clk);
    chk(rd_n - r0, 8'h01);
    ext_req <= 1'b0;
    repeat (6) @(posedge clk);
    ext_req <= 1'b1;
    done_chk(8'h02);
    tally_and_finish();
  end
endmodule : two_channel_dma_control_bench
